// ==== bpsr_regs.sv ====
`timescale 1ns/1ps
// Operation
// RL1 - Live status bit 12 shows receive link up, read-only.
// RL2 - Live status bit 2 always reads 1, PRBS31 testing supported.
// RL3 - Live status bit 1 shows live high error rate.
// RL4 - Live status bit 0 shows live block lock.
// RL5 - Latched status bit 15 latches lock loss low until host read.
// RL6 - Latched status bit 14 latches high error rate until host read.
// RL7 - Bits 13:8 count bad sync header entries, cleared on read.
// RL8 - Bits 7:0 count decoder error state entries, cleared on read.
// RL9 - Errored count mirrored at second location; either read clears it.
// RL10 - Offset 0x22 holds seed A bits 15:0, read-write, reset zero.
// RL11 - Offset 0x23 holds seed A bits 31:16, read-write, reset zero.
// RL12 - Offset 0x24 holds seed A bits 47:32, read-write, reset zero.
// RL13 - Latched status register resets to all zeros.
// RL14 - Seed A is 58 bits; top ten at 0x25, upper six read zero.
// RL15 - Counters saturate; latched bits reload from live state after read.
// RL16 - Host reads latched register to start a fresh measurement.
module bpsr_regs (
   input  wire logic                clk_sys,
   input  wire logic                rst_n,
   input  wire bpsr_pkg::bpsr_live_t live_in,
   input  wire bpsr_pkg::bpsr_req_t  req,
   output logic [15:0]              rdata_r,
   output logic                     rvalid_r,
   output logic [57:0]              pattern_seed_a_r
);

   // ==========================================================
   // Input synchronisers for status from the PCS core
   logic [4:0] sync1_r;
   logic [4:0] sync2_r;
   logic [4:0] sync_nxt;
   bpsr_pkg::bpsr_live_t live_s;

   // Stage one feeds only stage two
   always_comb begin
      sync_nxt = live_in;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= 5'h00;
         sync2_r <= 5'h00;
      end else begin
         sync1_r <= sync_nxt;
         sync2_r <= sync1_r;
      end
   end

   assign live_s = bpsr_pkg::bpsr_live_t'(sync2_r);

   // ==========================================================
   // Event edge detection on synchronised state entries
   logic bsh_prev_r;
   logic err_prev_r;
   logic bsh_prev_nxt;
   logic err_prev_nxt;
   logic bsh_evt;
   logic err_evt;

   always_comb begin
      bsh_prev_nxt = live_s.bad_sync_header_state_entry;
      err_prev_nxt = live_s.rx_error_state_entry;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bsh_prev_r <= 1'b0;
         err_prev_r <= 1'b0;
      end else begin
         bsh_prev_r <= bsh_prev_nxt;
         err_prev_r <= err_prev_nxt;
      end
   end

   assign bsh_evt = live_s.bad_sync_header_state_entry & ~bsh_prev_r;
   assign err_evt = live_s.rx_error_state_entry & ~err_prev_r;

   // ==========================================================
   // Read strobes
   logic rd_latched;
   logic rd_mirror;

   assign rd_latched = req.rd && (req.addr == bpsr_pkg::OFF_LATCHED_STAT);
   assign rd_mirror  = req.rd && (req.addr == bpsr_pkg::OFF_ERR_MIRROR);

   // ==========================================================
   // Clear-on-read counters
   logic [bpsr_pkg::BSH_W-1:0] bad_sync_header_count;
   logic [bpsr_pkg::ERR_W-1:0] errored_block_count;

   // Bad sync header entries, saturating
   bpsr_sat_counter #(
      .W        (bpsr_pkg::BSH_W)
   ) u_bsh_cnt (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .event_in (bsh_evt),                  // [RL7] [RL15]
      .clear    (rd_latched),               // [RL7]
      .count_r  (bad_sync_header_count)
   );

   // Errored blocks, shared by both read locations
   bpsr_sat_counter #(
      .W        (bpsr_pkg::ERR_W)
   ) u_err_cnt (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .event_in (err_evt),                  // [RL8] [RL15]
      .clear    (rd_latched | rd_mirror),   // [RL9]
      .count_r  (errored_block_count)
   );

   // ==========================================================
   // Latched status bits
   logic block_lock_latched_low_r;
   logic high_error_rate_latched_r;
   logic lock_ll_nxt;
   logic hber_lh_nxt;
   logic primed_r;
   logic primed_nxt;

   // Latch-low lock and latch-high error rate, read reloads from live
   always_comb begin
      primed_nxt  = 1'b1;
      lock_ll_nxt = block_lock_latched_low_r;
      hber_lh_nxt = high_error_rate_latched_r;
      if (rd_latched || !primed_r) begin
         lock_ll_nxt = live_s.block_lock_live;       // [RL15] [RL16]
         hber_lh_nxt = live_s.high_error_rate_live;  // [RL15]
      end else begin
         lock_ll_nxt = block_lock_latched_low_r & live_s.block_lock_live;      // [RL5]
         hber_lh_nxt = high_error_rate_latched_r | live_s.high_error_rate_live; // [RL6]
      end
      if (!primed_r) begin
         lock_ll_nxt = 1'b0;
         hber_lh_nxt = 1'b0;
         primed_nxt  = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         block_lock_latched_low_r  <= bpsr_pkg::RST_LATCHED[bpsr_pkg::BIT_LOCK_LL];   // [RL13]
         high_error_rate_latched_r <= bpsr_pkg::RST_LATCHED[bpsr_pkg::BIT_HI_BER_LH]; // [RL13]
         primed_r                  <= 1'b0;
      end else begin
         block_lock_latched_low_r  <= lock_ll_nxt;
         high_error_rate_latched_r <= hber_lh_nxt;
         primed_r                  <= primed_nxt;
      end
   end

   // ==========================================================
   // Seed A storage
   logic [57:0] seed_nxt;

   // Word writes into the seed, reserved top bits dropped
   always_comb begin
      seed_nxt = pattern_seed_a_r;
      if (req.wr) begin
         case (req.addr)
            bpsr_pkg::OFF_SEED_A0: seed_nxt[15:0]  = req.wdata;                            // [RL10]
            bpsr_pkg::OFF_SEED_A1: seed_nxt[31:16] = req.wdata;                            // [RL11]
            bpsr_pkg::OFF_SEED_A2: seed_nxt[47:32] = req.wdata;                            // [RL12]
            bpsr_pkg::OFF_SEED_A3: seed_nxt[57:48] = req.wdata[bpsr_pkg::SEED_TOP_W-1:0]; // [RL14]
            default:               seed_nxt = pattern_seed_a_r;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pattern_seed_a_r <= {bpsr_pkg::RST_SEED[9:0], bpsr_pkg::RST_SEED,
                              bpsr_pkg::RST_SEED, bpsr_pkg::RST_SEED};
      end else begin
         pattern_seed_a_r <= seed_nxt;
      end
   end

   // ==========================================================
   // Read mux, data registered one cycle after the request
   logic [15:0] rdata_nxt;
   logic        rvalid_nxt;

   always_comb begin
      rdata_nxt  = bpsr_pkg::RD_UNMAPPED;
      rvalid_nxt = req.rd;
      case (req.addr)
         bpsr_pkg::OFF_LIVE_STATUS: begin
            rdata_nxt[bpsr_pkg::BIT_RX_LINK]    = live_s.receive_link_up;      // [RL1]
            rdata_nxt[bpsr_pkg::BIT_PRBS31_CAP] = 1'b1;                        // [RL2]
            rdata_nxt[bpsr_pkg::BIT_HI_BER]     = live_s.high_error_rate_live; // [RL3]
            rdata_nxt[bpsr_pkg::BIT_BLOCK_LOCK] = live_s.block_lock_live;      // [RL4]
         end
         bpsr_pkg::OFF_LATCHED_STAT: begin
            rdata_nxt[bpsr_pkg::BIT_LOCK_LL]   = block_lock_latched_low_r;      // [RL5]
            rdata_nxt[bpsr_pkg::BIT_HI_BER_LH] = high_error_rate_latched_r;     // [RL6]
            rdata_nxt[bpsr_pkg::BSH_LSB +: bpsr_pkg::BSH_W] = bad_sync_header_count; // [RL7]
            rdata_nxt[bpsr_pkg::ERR_LSB +: bpsr_pkg::ERR_W] = errored_block_count;   // [RL8]
         end
         bpsr_pkg::OFF_ERR_MIRROR: begin
            rdata_nxt[bpsr_pkg::ERR_LSB +: bpsr_pkg::ERR_W] = errored_block_count;   // [RL9]
         end
         bpsr_pkg::OFF_SEED_A0: rdata_nxt = pattern_seed_a_r[15:0];
         bpsr_pkg::OFF_SEED_A1: rdata_nxt = pattern_seed_a_r[31:16];
         bpsr_pkg::OFF_SEED_A2: rdata_nxt = pattern_seed_a_r[47:32];
         bpsr_pkg::OFF_SEED_A3: rdata_nxt = {6'h00, pattern_seed_a_r[57:48]};        // [RL14]
         default:               rdata_nxt = bpsr_pkg::RD_UNMAPPED;
      endcase
      if (!req.rd) begin
         rdata_nxt = rdata_r;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r  <= 16'h0000;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r  <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

endmodule : bpsr_regs

// ==== bpsr_pkg.sv ====
package bpsr_pkg;

   // ==========================================================
   // Register offsets (word addresses on the management bus)
   localparam logic [15:0] OFF_LIVE_STATUS   = 16'h0020;
   localparam logic [15:0] OFF_LATCHED_STAT  = 16'h0021;
   localparam logic [15:0] OFF_SEED_A0       = 16'h0022;
   localparam logic [15:0] OFF_SEED_A1       = 16'h0023;
   localparam logic [15:0] OFF_SEED_A2       = 16'h0024;
   localparam logic [15:0] OFF_SEED_A3       = 16'h0025;
   localparam logic [15:0] OFF_ERR_MIRROR    = 16'h0010;

   // ==========================================================
   // Field positions
   localparam int BIT_RX_LINK     = 12;
   localparam int BIT_PRBS31_CAP  = 2;
   localparam int BIT_HI_BER      = 1;
   localparam int BIT_BLOCK_LOCK  = 0;
   localparam int BIT_LOCK_LL     = 15;
   localparam int BIT_HI_BER_LH   = 14;
   localparam int BSH_LSB         = 8;
   localparam int BSH_W           = 6;
   localparam int ERR_LSB         = 0;
   localparam int ERR_W           = 8;
   localparam int SEED_TOP_W      = 10;

   // ==========================================================
   // Reset values and unmapped read value
   localparam logic [15:0] RST_LATCHED       = 16'h0000;
   localparam logic [15:0] RST_SEED          = 16'h0000;
   localparam logic [15:0] RD_UNMAPPED       = 16'h0000;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic receive_link_up;
      logic high_error_rate_live;
      logic block_lock_live;
      logic bad_sync_header_state_entry;
      logic rx_error_state_entry;
   } bpsr_live_t;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } bpsr_req_t;

endpackage : bpsr_pkg

// ==== bpsr_sat_counter.sv ====
`timescale 1ns/1ps
module bpsr_sat_counter #(
   parameter int W = 8
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic         event_in,
   input  wire logic         clear,
   output logic [W-1:0]      count_r
);

   logic [W-1:0] count_nxt;

   // ==========================================================
   // Saturating count, an event in the clear cycle counts as one
   always_comb begin
      count_nxt = clear ? '0 : count_r;
      if (event_in && (count_nxt != {W{1'b1}})) begin
         count_nxt = count_nxt + 1'b1;
      end
   end

   // Register
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= '0;
      end else begin
         count_r <= count_nxt;
      end
   end

endmodule : bpsr_sat_counter

// ==== bpsr_regs_props.sv ====
`timescale 1ns/1ps
// ==========
// Port checks on the status and seed registers
module bpsr_regs_props (
   input wire logic                 clk_sys,
   input wire logic                 rst_n,
   input wire bpsr_pkg::bpsr_live_t live_in,
   input wire bpsr_pkg::bpsr_req_t  req,
   input wire logic [15:0]          rdata_r,
   input wire logic                 rvalid_r,
   input wire logic [57:0]          pattern_seed_a_r
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // Request shapes
   sequence rd_s(logic [15:0] a);
      req.rd && req.addr == a;
   endsequence
   sequence wr_s(logic [15:0] a);
      req.wr && req.addr == a;
   endsequence
   sequence calm_rd_s;
      $stable(live_in) [*4] ##0 rd_s(bpsr_pkg::OFF_LIVE_STATUS);
   endsequence
   // Live status word and mirror upper bits
   prbs_cap_a: assert property (rd_s(bpsr_pkg::OFF_LIVE_STATUS) |=> rvalid_r && rdata_r[2])
      else $error("capability bit low");
   link_bit_a: assert property (calm_rd_s |=> rdata_r[12] == $past(live_in.receive_link_up))
      else $error("link bit wrong");
   ber_lock_a: assert property (calm_rd_s |=> rdata_r[1:0] == $past({live_in.high_error_rate_live,
      live_in.block_lock_live}))
      else $error("ber or lock bit wrong");
   mirror_hi_a: assert property (rd_s(bpsr_pkg::OFF_ERR_MIRROR) |=> rvalid_r && rdata_r[15:8] == 8'h00)
      else $error("mirror upper bits set");
   // Seed words
   seed_lo_a: assert property (wr_s(bpsr_pkg::OFF_SEED_A0) |=> pattern_seed_a_r[15:0] == $past(req.wdata))
      else $error("seed word 0 not stored");
   seed_mid_a: assert property (wr_s(bpsr_pkg::OFF_SEED_A1) |=> pattern_seed_a_r[31:16] == $past(req.wdata))
      else $error("seed word 1 not stored");
   seed_hi_a: assert property (wr_s(bpsr_pkg::OFF_SEED_A2) |=> pattern_seed_a_r[47:32] == $past(req.wdata))
      else $error("seed word 2 not stored");
   seed_top_a: assert property (wr_s(bpsr_pkg::OFF_SEED_A3) |=> pattern_seed_a_r[57:48] == $past(req.wdata[9:0]))
      else $error("seed top bits not stored");
   seed_rst_a: assert property ($rose(rst_n) |-> pattern_seed_a_r == 58'h0)
      else $error("seed not zero after reset");
   seed_keep_a: assert property (!req.wr |=> $stable(pattern_seed_a_r))
      else $error("seed moved without write");
endmodule : bpsr_regs_props

bind bpsr_regs bpsr_regs_props u_props (.clk_sys(clk_sys), .rst_n(rst_n), .live_in(live_in), .req(req),
   .rdata_r(rdata_r), .rvalid_r(rvalid_r), .pattern_seed_a_r(pattern_seed_a_r));

// ==== bpsr_pcs_model.sv ====
`timescale 1ns/1ps
// ==========
// Far-side receive state machines feeding live status
module bpsr_pcs_model (
   input  wire logic            clk_sys,
   input  wire logic            link,
   input  wire logic            hi_ber,
   input  wire logic            lock,
   input  wire logic            bsh_go,
   input  wire logic            err_go,
   output bpsr_pkg::bpsr_live_t live_out
);
   // Levels passed on, entries as one-cycle pulses
   always_ff @(posedge clk_sys) begin
      live_out <= '{link, hi_ber, lock, bsh_go, err_go};
   end
endmodule : bpsr_pcs_model

// ==== baser_pcs_status_seed_regs_tb.sv ====
`timescale 1ns/1ps
// ==========
// Self-checking bench for the status and seed registers
module baser_pcs_status_seed_regs_tb;
   logic                 clk_sys = 1'b0;
   logic                 rst_n = 1'b0;
   logic                 link = 1'b0, hi_ber = 1'b0, lock = 1'b0, bsh_go = 1'b0, err_go = 1'b0;
   bpsr_pkg::bpsr_live_t live_in;
   bpsr_pkg::bpsr_req_t  req = '0;
   logic [15:0]          rdata_r, w [4];
   logic                 rvalid_r;
   logic [57:0]          pattern_seed_a_r;
   logic [15:0]          exp_q [$];
   int                   fails = 0, compares = 0, n, m;

   always #12.5 clk_sys = ~clk_sys;

   bpsr_pcs_model u_pcs (.clk_sys(clk_sys), .link(link), .hi_ber(hi_ber), .lock(lock),
      .bsh_go(bsh_go), .err_go(err_go), .live_out(live_in));
   bpsr_regs DUT (.clk_sys(clk_sys), .rst_n(rst_n), .live_in(live_in), .req(req),
      .rdata_r(rdata_r), .rvalid_r(rvalid_r), .pattern_seed_a_r(pattern_seed_a_r));

   // ==========
   // Compare and verdict
   task automatic chk(logic [63:0] got, logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic close_out();
      if (exp_q.size() != 0) fails++; // Read answers that never came
      if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   // Host accesses; strobe held until the next access or idle
   task automatic rd(logic [15:0] a, logic [15:0] e);
      exp_q.push_back(e);
      req.rd = 1'b1; req.wr = 1'b0; req.addr = a;
      @(negedge clk_sys);
   endtask : rd
   task automatic wr(logic [15:0] a, logic [15:0] d);
      req.rd = 1'b0; req.wr = 1'b1; req.addr = a; req.wdata = d;
      @(negedge clk_sys);
   endtask : wr
   task automatic idle(int c);
      req.rd = 1'b0; req.wr = 1'b0;
      repeat (c) @(negedge clk_sys);
   endtask : idle
   // One entry event, high one cycle then low one cycle
   task automatic ev(logic b, logic e);
      bsh_go = b; err_go = e;
      @(negedge clk_sys);
      bsh_go = 1'b0; err_go = 1'b0;
      @(negedge clk_sys);
   endtask : ev

   // Read answers matched against the oldest note
   always @(negedge clk_sys) begin
      if (rvalid_r === 1'b1) chk(rdata_r, exp_q.pop_front());
   end

   // ==========
   // Main sequence
   initial begin
      void'($urandom(72391));
      repeat (8) @(negedge clk_sys);
      rst_n = 1'b1;
      @(negedge clk_sys);
      chk(pattern_seed_a_r, 58'h0);
      rd(bpsr_pkg::OFF_LATCHED_STAT, 16'h0000);
      rd(bpsr_pkg::OFF_LIVE_STATUS, 16'h0004);
      link = 1'b1; lock = 1'b1;
      idle(5);
      rd(bpsr_pkg::OFF_LIVE_STATUS, 16'h1005);
      rd(bpsr_pkg::OFF_LATCHED_STAT, 16'h0000);
      rd(bpsr_pkg::OFF_LATCHED_STAT, 16'h8000);
      lock = 1'b0;
      idle(3);
      lock = 1'b1; hi_ber = 1'b1;
      idle(5);
      rd(bpsr_pkg::OFF_LIVE_STATUS, 16'h1007);
      hi_ber = 1'b0;
      idle(5);
      rd(bpsr_pkg::OFF_LATCHED_STAT, 16'h4000);
      rd(bpsr_pkg::OFF_LATCHED_STAT, 16'h8000);
      idle(1);
      // Random event counts, then clear through each location
      n = $urandom_range(1, 20);
      m = $urandom_range(21, 40);
      for (int i = 0; i < m; i++) ev(i < n, 1'b1);
      idle(5);
      rd(bpsr_pkg::OFF_LATCHED_STAT, {2'b10, n[5:0], m[7:0]});
      rd(bpsr_pkg::OFF_LATCHED_STAT, 16'h8000);
      idle(1);
      for (int i = 0; i < n; i++) ev(1'b0, 1'b1);
      idle(5);
      rd(bpsr_pkg::OFF_ERR_MIRROR, {8'h00, n[7:0]});
      rd(bpsr_pkg::OFF_LATCHED_STAT, 16'h8000);
      idle(1);
      for (int i = 0; i < 300; i++) ev(i < 70, 1'b1);
      idle(5);
      rd(bpsr_pkg::OFF_LATCHED_STAT, 16'hbfff);
      // Seed words back to back, then writes to read-only places
      foreach (w[i]) w[i] = 16'($urandom());
      for (int i = 0; i < 4; i++) wr(bpsr_pkg::OFF_SEED_A0 + 16'(i), w[i]);
      wr(bpsr_pkg::OFF_LIVE_STATUS, 16'hffff);
      wr(bpsr_pkg::OFF_LATCHED_STAT, 16'hffff);
      idle(1);
      chk(pattern_seed_a_r, {w[3][9:0], w[2], w[1], w[0]});
      rd(bpsr_pkg::OFF_SEED_A3, {6'h00, w[3][9:0]});
      rd(bpsr_pkg::OFF_SEED_A1, w[1]);
      rd(bpsr_pkg::OFF_LIVE_STATUS, 16'h1005);
      rd(16'h0030, 16'h0000);
      rd(bpsr_pkg::OFF_LATCHED_STAT, 16'h8000);
      idle(4);
      close_out();
   end

   // Watchdog well beyond the expected run
   initial begin
      repeat (5000) @(posedge clk_sys);
      fails++;
      close_out();
   end
endmodule : baser_pcs_status_seed_regs_tb
